/* File: logic/epc_pkg.sv */
// package: constants and types shared by the emulator probe control block
`default_nettype none
package epc_pkg;
    // ==========================================================
    // register byte offsets on the apb bus
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_UNIT = 12'h008;
    // ==========================================================
    // control register field positions
    localparam int CTL_COMB_RDY = 0;
    localparam int CTL_BUS_WD = 1;
    localparam int CTL_IO_WD = 2;
    localparam int CTL_MEM_WD = 3;
    localparam int CTL_CP_WD = 4;
    localparam int CTL_CP_EN = 5;
    localparam int CTL_CP_MODE = 6;
    localparam int CTL_RST_PERMIT = 8;
    localparam int CTL_BUS_TRACE = 9;
    localparam int CTL_EMULATE = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;
    // ==========================================================
    // status register field positions
    localparam int ST_TIMEOUT = 0;
    localparam int ST_CAUSE = 1;
    localparam int ST_PROT = 5;
    localparam int ST_KIND = 8;
    // ==========================================================
    // coprocessor run modes
    localparam logic [1:0] CP_MODE_EMUL = 2'h1;
    localparam logic [1:0] CP_MODE_ALWAYS = 2'h2;
    // ==========================================================
    // timing: one second watchdog at 10 MHz
    localparam longint CLK_HZ = 10_000_000;
    localparam longint WD_TIME_MS = 1000;
    localparam longint WD_CYCLES = (WD_TIME_MS * CLK_HZ) / 1000;
    // ==========================================================
    // probe kind label, value arbitrary
    localparam logic [7:0] KIND_DEFAULT = 8'h5a;
endpackage
`default_nettype wire

/* File: logic/epc_wd_if.sv */
// interface: control and event lines between top and one watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface epc_wd_if;
    logic enable;
    logic restart;
    logic active;
    logic expired;
    modport ctl (output enable, output restart, output active, input expired);
    modport cnt (input enable, input restart, input active, output expired);
endinterface
`default_nettype wire

/* File: logic/epc_watchdog.sv */
// module: one-second watchdog counter used for every timeout source
`timescale 1ns/1ps
`default_nettype none
module epc_watchdog #(
    parameter int CW = 24,
    parameter longint LIMIT = epc_pkg::WD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    epc_wd_if.cnt wd
);
    logic [CW-1:0] cnt_q, cnt_d;
    logic exp_q, exp_d;
    localparam logic [CW-1:0] TERM = CW'(LIMIT - 1);
    // ==========================================================
    // counter restarts on activity, counts while watched condition holds
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (!wd.enable || wd.restart || !wd.active) begin
            cnt_d = '0;
        end else if (cnt_q == TERM) begin
            exp_d = 1'b1; // one-cycle event at terminal count
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end
    assign wd.expired = exp_q;
    // expiry only follows a cycle in which the watchdog was enabled and active
    a_wd_no_early: assert property (@(posedge clk) disable iff (sys_rst)
        wd.expired |-> $past(wd.enable) && $past(wd.active)) else $error("early expiry");
endmodule
`default_nettype wire

/* File: logic/epc_probe_ctrl.sv */
// module: emulator probe control, ready select, watchdogs, gating, status
// ==========================================================
// Notes on behaviour
// - combined option set: processor ready is mapped ready AND prototype ready.
// - combined option clear: processor ready is mapped ready only.
// - bus idle watchdog stops emulation after one second without bus activity.
// - io watchdog stops emulation when one io access exceeds one second.
// - memory watchdog stops emulation when one memory access exceeds one second.
// - coprocessor watchdog stops emulation on coprocessor access over one second.
// - coprocessor enable output follows the coprocessor enable setting.
// - run mode 1 runs coprocessor only while emulating; mode 2 always.
// - permit set: prototype reset resets processor, only during emulation.
// - permit clear: prototype reset line is ignored entirely.
// - bus trace set: record execution and bus cycle information.
// - bus trace clear: record execution information only.
// - readable probe kind label; status selectable per unit 0 to 3.
// - execution mode label shows real or protected mode.
`timescale 1ns/1ps
`default_nettype none
module epc_probe_ctrl #(
    parameter longint WD_LIMIT = epc_pkg::WD_CYCLES,
    parameter logic [7:0] PROBE_KIND = epc_pkg::KIND_DEFAULT,
    parameter logic [1:0] UNIT_ID = 2'h0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic map_ready,
    input wire logic proto_ready,
    output logic cpu_ready,
    input wire logic bus_cycle,
    input wire logic io_access,
    input wire logic mem_access,
    input wire logic cp_access,
    input wire logic cycle_done,
    input wire logic cpu_protected,
    input wire logic proto_reset,
    output logic cpu_reset,
    output logic emul_stop,
    output logic coproc_enable,
    output logic coproc_run,
    input wire logic trace_exec_valid,
    input wire logic trace_bus_valid,
    output logic trace_exec_we,
    output logic trace_bus_we
);
    // ==========================================================
    // settings register and timeout status
    logic [31:0] ctrl_q, ctrl_d;
    logic to_q, to_d;
    logic [3:0] cause_q, cause_d;
    logic [1:0] unit_q, unit_d;
    logic [31:0] rdata_q, rdata_d;
    logic combined_ready_sel, bus_idle_watchdog_en, io_access_watchdog_en;
    logic mem_access_watchdog_en, coproc_hang_watchdog_en, external_reset_permit;
    logic bus_trace_sel, emulating, setting_coproc_enable;
    logic [1:0] coproc_run_mode;
    logic [3:0] expired;
    logic wr, rd, unit_match;
    logic [31:0] stat_word;

    assign combined_ready_sel = ctrl_q[epc_pkg::CTL_COMB_RDY];
    assign bus_idle_watchdog_en = ctrl_q[epc_pkg::CTL_BUS_WD];
    assign io_access_watchdog_en = ctrl_q[epc_pkg::CTL_IO_WD];
    assign mem_access_watchdog_en = ctrl_q[epc_pkg::CTL_MEM_WD];
    assign coproc_hang_watchdog_en = ctrl_q[epc_pkg::CTL_CP_WD];
    assign setting_coproc_enable = ctrl_q[epc_pkg::CTL_CP_EN];
    assign coproc_run_mode = ctrl_q[epc_pkg::CTL_CP_MODE +: 2];
    assign external_reset_permit = ctrl_q[epc_pkg::CTL_RST_PERMIT];
    assign bus_trace_sel = ctrl_q[epc_pkg::CTL_BUS_TRACE];
    assign emulating = ctrl_q[epc_pkg::CTL_EMULATE] && !to_q;

    // ==========================================================
    // watchdogs: bus idle, io, memory, coprocessor access
    epc_wd_if wd_bus ();
    epc_wd_if wd_io ();
    epc_wd_if wd_mem ();
    epc_wd_if wd_cp ();
    assign wd_bus.enable = bus_idle_watchdog_en && emulating;
    assign wd_bus.restart = bus_cycle; // any bus activity restarts it
    assign wd_bus.active = 1'b1;
    assign wd_io.enable = io_access_watchdog_en && emulating;
    assign wd_io.restart = cycle_done;
    assign wd_io.active = io_access;
    assign wd_mem.enable = mem_access_watchdog_en && emulating;
    assign wd_mem.restart = cycle_done;
    assign wd_mem.active = mem_access;
    assign wd_cp.enable = coproc_hang_watchdog_en && emulating;
    assign wd_cp.restart = cycle_done;
    assign wd_cp.active = cp_access;
    epc_watchdog #(.LIMIT(WD_LIMIT)) u_wd_bus (.clk(clk), .sys_rst(sys_rst), .wd(wd_bus));
    epc_watchdog #(.LIMIT(WD_LIMIT)) u_wd_io (.clk(clk), .sys_rst(sys_rst), .wd(wd_io));
    epc_watchdog #(.LIMIT(WD_LIMIT)) u_wd_mem (.clk(clk), .sys_rst(sys_rst), .wd(wd_mem));
    epc_watchdog #(.LIMIT(WD_LIMIT)) u_wd_cp (.clk(clk), .sys_rst(sys_rst), .wd(wd_cp));
    assign expired = {wd_cp.expired, wd_mem.expired, wd_io.expired, wd_bus.expired};

    // ==========================================================
    // apb decode; no wait states, so pready is always high
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign unit_match = (unit_q == UNIT_ID);
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // status word: unit other than this one reads zero
    assign stat_word = unit_match ?
        {16'h0000, PROBE_KIND, 2'b00, cpu_protected, cause_q, to_q} : 32'h0000_0000;

    // ==========================================================
    // register next-state; hardware timeout set wins over software clear
    always_comb begin
        ctrl_d = ctrl_q;
        to_d = to_q;
        cause_d = cause_q;
        unit_d = unit_q;
        rdata_d = rdata_q;
        if (wr && paddr == epc_pkg::OFF_CTRL) begin
            ctrl_d = pwdata & epc_pkg::CTRL_MASK;
        end
        if (wr && paddr == epc_pkg::OFF_UNIT) begin
            unit_d = pwdata[1:0];
        end
        // writing one to the timeout bit clears it and its cause
        if (wr && paddr == epc_pkg::OFF_STAT && pwdata[epc_pkg::ST_TIMEOUT]) begin
            to_d = 1'b0;
            cause_d = 4'h0;
        end
        if (|expired) begin
            to_d = 1'b1; // stop emulation with timeout
            cause_d = cause_q | expired;
        end
        // read data captured in setup, presented through the access phase
        if (rd) begin
            unique case (paddr)
                epc_pkg::OFF_CTRL: rdata_d = ctrl_q;
                epc_pkg::OFF_STAT: rdata_d = stat_word;
                epc_pkg::OFF_UNIT: rdata_d = {30'h0, unit_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= epc_pkg::CTRL_RESET;
            to_q <= 1'b0;
            cause_q <= 4'h0;
            unit_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            to_q <= to_d;
            cause_q <= cause_d;
            unit_q <= unit_d;
            rdata_q <= rdata_d;
        end
    end
    assign prdata = rdata_q;
    assign emul_stop = to_q;

    // ==========================================================
    // ready select, reset gating, coprocessor gating, trace select
    // combinational so the ready path adds no wait state
    always_comb begin
        if (combined_ready_sel) begin
            cpu_ready = map_ready && proto_ready;
        end else begin
            cpu_ready = map_ready; // prototype ready ignored
        end
        // reset from prototype passes only when permitted and emulating
        cpu_reset = external_reset_permit && emulating && proto_reset;
        coproc_enable = setting_coproc_enable;
        // an unlisted mode code keeps the coprocessor stopped as the safe choice
        unique case (coproc_run_mode)
            epc_pkg::CP_MODE_EMUL: coproc_run = setting_coproc_enable && emulating;
            epc_pkg::CP_MODE_ALWAYS: coproc_run = setting_coproc_enable;
            default: coproc_run = 1'b0;
        endcase
        trace_exec_we = trace_exec_valid; // execution always traced
        trace_bus_we = trace_bus_valid && bus_trace_sel;
    end

    // ==========================================================
    // checks
    a_ready_and: assert property (@(posedge clk) disable iff (sys_rst)
        combined_ready_sel && !proto_ready |-> !cpu_ready) else $error("ready and");
    a_ready_map: assert property (@(posedge clk) disable iff (sys_rst)
        !combined_ready_sel |-> cpu_ready == map_ready) else $error("ready map");
    a_to_latch: assert property (@(posedge clk) disable iff (sys_rst)
        |expired |=> emul_stop) else $error("timeout lost");
    sequence s_io_long;
        io_access_watchdog_en && emulating && io_access && !cycle_done;
    endsequence
    a_io_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(io_access_watchdog_en) |-> !wd_io.expired) else $error("io disabled fired");
    a_mem_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(mem_access_watchdog_en) |-> !wd_mem.expired) else $error("mem fired");
    a_cp_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(coproc_hang_watchdog_en) |-> !wd_cp.expired) else $error("cp fired");
    a_cp_enable: assert property (@(posedge clk) disable iff (sys_rst)
        !coproc_enable |-> !coproc_run) else $error("coproc ran disabled");
    a_cp_mode1: assert property (@(posedge clk) disable iff (sys_rst)
        coproc_run_mode == epc_pkg::CP_MODE_EMUL && !emulating |-> !coproc_run)
        else $error("mode one ran");
    a_rst_gate: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_reset |-> proto_reset && external_reset_permit && emulating)
        else $error("reset leaked");
    a_trace_bus: assert property (@(posedge clk) disable iff (sys_rst)
        !bus_trace_sel |-> !trace_bus_we) else $error("bus traced");
    a_io_hold: assert property (@(posedge clk) disable iff (sys_rst)
        s_io_long [*2] |-> !emul_stop || $past(emul_stop)) else $error("io stop");
endmodule
`default_nettype wire

/* File: sim/epc_proto_model.sv */
// partner model: prototype board bus logic driving accesses, ready and reset
`timescale 1ns/1ps
`default_nettype none
module epc_proto_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [15:0] len,
    input wire logic stall,
    input wire logic rst_req,
    output logic proto_ready,
    output logic proto_reset,
    output logic bus_cycle,
    output logic io_access,
    output logic mem_access,
    output logic cp_access,
    output logic cycle_done
);
    logic [15:0] left_q = 16'h0000;
    logic busy_q = 1'b0;
    // ==========================================================
    // access sequencing
    // one access: strobe bus activity, hold the access line for len cycles
    always @(posedge clk) begin
        bus_cycle <= go;
        if (go) begin
            busy_q <= 1'b1;
            left_q <= len;
        end else if (busy_q) begin
            left_q <= left_q - 16'h0001;
            busy_q <= (left_q != 16'h0001);
        end
    end
    // done marks the last access cycle; ready stays low until then, like slow prototype memory
    assign cycle_done = busy_q && left_q == 16'h0001;
    assign proto_ready = !stall && !(busy_q && left_q != 16'h0001);
    assign io_access = busy_q && kind == 2'h1;
    assign mem_access = busy_q && kind == 2'h2;
    assign cp_access = busy_q && kind == 2'h3;
    assign proto_reset = rst_req;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench: register access, ready select, gating, trace and watchdog scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LIM = 16;
    localparam logic [31:0] KW = {16'h0000, epc_pkg::KIND_DEFAULT, 8'h00};
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pready, pslverr, map_ready = 1'b1, proto_ready, cpu_ready, bus_cycle, io_access;
    logic mem_access, cp_access, cycle_done, cpu_protected = 1'b0, proto_reset, cpu_reset;
    logic emul_stop, coproc_enable, coproc_run, trace_exec_valid = 1'b0, trace_bus_valid = 1'b1;
    logic trace_exec_we, trace_bus_we, go = 1'b0, stall = 1'b0, rst_req = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [15:0] len = 16'h0001;
    int mismatches = 0, num_checks = 0;
    epc_probe_ctrl #(.WD_LIMIT(LIM)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .map_ready(map_ready), .proto_ready(proto_ready),
        .cpu_ready(cpu_ready), .bus_cycle(bus_cycle), .io_access(io_access),
        .mem_access(mem_access), .cp_access(cp_access), .cycle_done(cycle_done),
        .cpu_protected(cpu_protected), .proto_reset(proto_reset), .cpu_reset(cpu_reset),
        .emul_stop(emul_stop), .coproc_enable(coproc_enable), .coproc_run(coproc_run),
        .trace_exec_valid(trace_exec_valid), .trace_bus_valid(trace_bus_valid),
        .trace_exec_we(trace_exec_we), .trace_bus_we(trace_bus_we));
    epc_proto_model model (.clk(clk), .go(go), .kind(kind), .len(len), .stall(stall),
        .rst_req(rst_req), .proto_ready(proto_ready), .proto_reset(proto_reset),
        .bus_cycle(bus_cycle), .io_access(io_access), .mem_access(mem_access),
        .cp_access(cp_access), .cycle_done(cycle_done));
    // ==========================================================
    // clock and watchdog
    initial forever #50 clk = ~clk;
    // a hung handshake or wait ends the run here
    initial begin
        #500_000;
        mismatches++;
        conclude();
    end
    // ==========================================================
    // shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an idle edge first so psel is never reassigned in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic access(input int n);
        len <= 16'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, epc_pkg::OFF_CTRL, 32'h0);
        chk(rdat, epc_pkg::CTRL_RESET);
        chk({30'h0, pready, pslverr}, 32'h2);
        // status only answers for its own unit number
        for (int u = 0; u < 4; u++) begin
            apb(1'b1, epc_pkg::OFF_UNIT, 32'(u));
            apb(1'b0, epc_pkg::OFF_STAT, 32'h0);
            chk(rdat, (u == 0) ? KW : 32'h0);
        end
        apb(1'b1, epc_pkg::OFF_UNIT, 32'h0);
        cpu_protected <= 1'b1;
        apb(1'b0, epc_pkg::OFF_STAT, 32'h0);
        chk(rdat, KW | 32'h0000_0020);
        cpu_protected <= 1'b0;
        apb(1'b0, epc_pkg::OFF_STAT, 32'h0);
        chk(rdat, KW);
        // unmapped place and bits above the control field change nothing
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, epc_pkg::OFF_CTRL, 32'hffff_f840);
        apb(1'b0, epc_pkg::OFF_CTRL, 32'h0);
        chk(rdat, 32'h0000_0040);
        // ready source table
        for (int i = 0; i < 8; i++) begin
            map_ready <= i[0];
            stall <= !i[1];
            apb(1'b1, epc_pkg::OFF_CTRL, 32'h40 | 32'(i[2]));
            @(posedge clk);
            chk({31'h0, cpu_ready}, {31'h0, i[2] ? i[0] & i[1] : i[0]});
        end
        stall <= 1'b0;
        map_ready <= 1'b1;
        // coprocessor gating in run modes 1 and 2, reset permit and trace selection over all their settings
        for (int i = 0; i < 64; i++) begin
            rst_req <= i[5];
            trace_exec_valid <= i[5];
            apb(1'b1, epc_pkg::OFF_CTRL, {21'h0, i[1], i[4], i[3], i[2], !i[2], i[0], 5'h0});
            @(posedge clk);
            chk({27'h0, coproc_enable, coproc_run, cpu_reset, trace_exec_we, trace_bus_we},
                {27'h0, i[0], i[0] & (i[2] | i[1]), i[3] & i[1] & i[5], i[5], i[4]});
        end
        rst_req <= 1'b0;
        // each watchdog alone: quiet before the limit, stopped after it
        for (int k = 0; k < 4; k++) begin
            kind <= 2'(k);
            apb(1'b1, epc_pkg::OFF_CTRL, 32'h440 | (32'h2 << k));
            if (k > 0) access(LIM + 6);
            repeat (LIM - 4) @(posedge clk);
            chk({31'h0, emul_stop}, 32'h0);
            repeat (10) @(posedge clk);
            chk({31'h0, emul_stop}, 32'h1);
            apb(1'b0, epc_pkg::OFF_STAT, 32'h0);
            chk(rdat & (32'h3 << k) | 32'h1, 32'h1 | (32'h2 << k));
            apb(1'b1, epc_pkg::OFF_CTRL, 32'h40);
            apb(1'b1, epc_pkg::OFF_STAT, 32'h1);
            repeat (2) @(posedge clk);
            chk({31'h0, emul_stop}, 32'h0);
        end
        // disabled watchdogs never stop a long access or a long idle bus
        kind <= 2'h2;
        apb(1'b1, epc_pkg::OFF_CTRL, 32'h440);
        access(3 * LIM);
        repeat (3 * LIM + 4) @(posedge clk);
        chk({31'h0, emul_stop}, 32'h0);
        // short accesses keep restarting every watchdog well past the limit
        apb(1'b1, epc_pkg::OFF_CTRL, 32'h45e);
        for (int j = 0; j < 12; j++) begin
            kind <= 2'(1 + j % 3);
            access(LIM - 6);
            repeat (LIM - 5) @(posedge clk);
        end
        chk({31'h0, emul_stop}, 32'h0);
        apb(1'b1, epc_pkg::OFF_CTRL, 32'h40);
        conclude();
    end
endmodule
`default_nettype wire
